// File: hw/convert_request_ctrl_pkg.sv
// Shared constants and types for the converter mode, power and multiplexer control
package convert_request_ctrl_pkg;

  // ----------------------------------------------------------------
  // Instruction layout (8-bit instruction, MSB first)
  // ----------------------------------------------------------------
  localparam int INSTR_BITS      = 8;
  localparam int INSTR_MUX_BIT   = 7;    // 1: channel select and convert
  localparam int INSTR_SE_BIT    = 6;    // Single-ended when set
  localparam int INSTR_CH_HI     = 5;    // Channel field [5:3]
  localparam int INSTR_CH_LO     = 3;
  localparam int INSTR_OP_HI     = 6;    // Opcode field [6:4] when bit 7 clear
  localparam int INSTR_OP_LO     = 4;

  typedef enum logic [2:0] {
    OP_POWER_UP   = 3'h0,
    OP_POWER_DOWN = 3'h1,
    OP_READ_STAT  = 3'h2,
    OP_SIGN_ON    = 3'h3,
    OP_SIGN_OFF   = 3'h4,
    OP_ACQ_TIME   = 3'h5,
    OP_TEST_MODE  = 3'h6,
    OP_USER_MODE  = 3'h7
  } opcode_type;

  // ----------------------------------------------------------------
  // Acquisition times in conversion clocks, selected by instr[1:0]
  // ----------------------------------------------------------------
  localparam logic [5:0] ACQ_CLK_6  = 6'h06;
  localparam logic [5:0] ACQ_CLK_10 = 6'h0a;
  localparam logic [5:0] ACQ_CLK_18 = 6'h12;
  localparam logic [5:0] ACQ_CLK_34 = 6'h22;
  localparam logic [1:0] ACQ_SEL_RESET = 2'h1;   // 10 clocks after reset

  // ----------------------------------------------------------------
  // Word lengths and status word layout
  // ----------------------------------------------------------------
  localparam logic [4:0] WORD_LEN_SIGNED   = 5'h0d;
  localparam logic [4:0] WORD_LEN_UNSIGNED = 5'h0c;
  localparam int STAT_TEST_BIT    = 9;
  localparam int STAT_PD_BIT      = 8;
  localparam int STAT_BUSY_BIT    = 7;
  localparam int STAT_VALID_BIT   = 6;
  localparam int STAT_SIGN_BIT    = 2;

  localparam logic [12:0] CODE_SE_MAX = 13'h0fff;   // Largest single-ended code

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       single_ended;
    logic [2:0] channel;
  } chan_cfg_type;

  localparam chan_cfg_type CHAN_CFG_RESET = '{single_ended: 1'b0, channel: 3'h0};

  typedef struct packed {
    logic [2:0] first_sel;      // Channel on the first mux output
    logic       second_common;  // Common input on the second mux output
    logic [2:0] second_sel;     // Channel on the second mux output
    logic       swap;           // First converter input is the negative one
  } mux_route_type;

  typedef enum logic [1:0] {
    CONVERT_REQUEST_IDLE    = 2'b00,
    CONVERT_REQUEST_ACQUIRE = 2'b01,
    CONVERT_REQUEST_RUN     = 2'b10
  } convert_request_state_type;

endpackage

// File: hw/convert_request_ctrl.sv
// Mode, power-down and multiplexer control of a serial successive-approximation converter
// Notes on behaviour
// - New channel configuration latched from instruction, applied as each conversion starts.
// - Pin or instruction power-down stops conversion logic; serial interface keeps working.
// - Software power-up while the pin is high leaves the device powered down.
// - Software power-down while the pin is low powers the device down.
// - Software power-down ends on power-up instruction or pin high-then-low pulse.
// - Power-down during conversion aborts it; following data is marked invalid.
// - Test instruction enters test mode; all eight channel pins become outputs.
// - Framing kept in test mode; reset or the user-mode instruction restores user mode.
// - Status word bit 9 high means test mode, low means user mode.
// - Convert request held high for a whole frame reads data without converting.
// - Result stays in the output register and can be reread each frame.
// - Eight channels: four differential pairs, eight single-ended, or any mix.
// - Differential pairs 0/1..6/7; even to first output, odd to second; either polarity.
// - Single-ended: channel to first output, common to second; first input positive.
// - Negative two's-complement codes when negative input exceeds the positive.
// - Single-ended codes have sign bit zero, range zero to 0 1111 1111 1111.
// - Signed differential codes span -4096 to +4095.
// - Reset defaults: 12 bits plus sign, MSB first, 10-clock acquisition, user, up.
// - Select falling during a conversion ends that conversion early.
`timescale 1ns/100ps

module convert_request_ctrl #(
  parameter int CODE_WIDTH = 13                          // Result width including sign
) (
  input  wire logic                         CLK_SYS,           // System clock, 40 MHz
  input  wire logic                         RSTN,              // Async reset, active low
  input  wire logic                         CS_N,              // Chip select pin
  input  wire logic                         SCLK,              // Serial clock pin
  input  wire logic                         DIN,               // Serial data in pin
  input  wire logic                         CONVERT_REQUEST_N, // Convert request pin
  input  wire logic                         POWER_DOWN_PIN,    // Hardware power-down pin
  input  wire logic                         CONVERSION_CLOCK,  // Conversion clock pin
  input  wire logic signed [CODE_WIDTH-1:0] SAMPLE_CODE,       // Comparator array result
  output logic                              DOUT,              // Serial data out
  output logic                              DATA_OUTPUT_READY, // High when word is done
  output convert_request_ctrl_pkg::mux_route_type      MUX_ROUTE,         // Multiplexer routing
  output logic                              CONVERTER_ENABLE,  // Conversion circuits on
  output logic                              SAMPLE_HOLD,       // Acquisition window
  output logic                              CONVERTING,        // Conversion under way
  output logic                              TEST_MODE,         // Test mode active
  output logic [7:0]                        CHANNEL_OE,        // Channel pins driven
  output logic [7:0]                        CHANNEL_OUT        // Channel pin levels
);

  // ------------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------------
  if (CODE_WIDTH != 13) begin : g_width_check
    $error("convert_request_ctrl supports CODE_WIDTH of 13 only");
  end

  // ------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------------
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [3:0] prev_reg;
  logic       cs_n_s;
  logic       sclk_s;
  logic       din_s;
  logic       convert_request_req_n_s;
  logic       pd_pin_s;
  logic       conversion_clock_s;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       cs_rise;
  logic       pd_pin_fall;
  logic       conversion_clock_rise;

  // Two stages on every pin; only the second stage is read
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      sync1_reg <= 6'h20;
      sync2_reg <= 6'h20;
    end else begin
      sync1_reg <= {CS_N, SCLK, DIN, CONVERT_REQUEST_N, POWER_DOWN_PIN, CONVERSION_CLOCK};
      sync2_reg <= sync1_reg;
    end
  end

  assign {cs_n_s, sclk_s, din_s, convert_request_req_n_s, pd_pin_s, conversion_clock_s} = sync2_reg;

  // Previous samples for edges of select, serial clock, pin and conversion clock
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      prev_reg <= 4'h8;
    end else begin
      prev_reg <= {cs_n_s, sclk_s, pd_pin_s, conversion_clock_s};
    end
  end

  assign cs_fall     = prev_reg[3] & ~cs_n_s;
  assign cs_rise     = ~prev_reg[3] & cs_n_s;
  assign sclk_rise   = ~cs_n_s & ~prev_reg[2] & sclk_s;
  assign sclk_fall   = ~cs_n_s & prev_reg[2] & ~sclk_s;
  assign pd_pin_fall = prev_reg[1] & ~pd_pin_s;
  assign conversion_clock_rise   = ~prev_reg[0] & conversion_clock_s;

  // ------------------------------------------------------------------
  // Serial framing
  // ------------------------------------------------------------------
  logic [4:0]            bit_cnt_reg;
  logic [7:0]            in_shift_reg;
  logic [CODE_WIDTH-1:0] out_shift_reg;
  logic                  instr_done_reg;
  logic                  req_seen_low_reg;
  logic                  sign_on_reg;
  logic [4:0]            word_len;
  logic                  word_end;
  logic                  instr_strobe;
  logic [7:0]            instr;
  logic [2:0]            opcode;
  logic                  frame_load;
  logic [CODE_WIDTH-1:0] load_word;
  logic                  show_status_reg;
  logic [CODE_WIDTH-1:0] status_word;
  logic [CODE_WIDTH-1:0] result_reg;
  logic                  skip_fall_reg;

  assign word_len     = sign_on_reg ? convert_request_ctrl_pkg::WORD_LEN_SIGNED
                                    : convert_request_ctrl_pkg::WORD_LEN_UNSIGNED;
  assign word_end     = sclk_rise & (bit_cnt_reg == word_len - 5'h01);
  assign instr        = {in_shift_reg[6:0], din_s};
  assign instr_strobe = sclk_rise & ~instr_done_reg &
                        (bit_cnt_reg == 5'(convert_request_ctrl_pkg::INSTR_BITS - 1));
  assign opcode       = instr[convert_request_ctrl_pkg::INSTR_OP_HI:convert_request_ctrl_pkg::INSTR_OP_LO];
  // A new word starts on select falling, or back to back with select held low
  assign frame_load   = cs_fall | word_end;
  assign load_word    = show_status_reg ? status_word : result_reg;

  // Bit counter and input shift; counts only serial clocks inside a frame
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      bit_cnt_reg    <= 5'h00;
      in_shift_reg   <= 8'h00;
      instr_done_reg <= 1'b0;
    end else if (cs_fall | cs_rise | word_end) begin
      bit_cnt_reg    <= 5'h00;
      instr_done_reg <= 1'b0;
    end else if (sclk_rise) begin
      bit_cnt_reg  <= bit_cnt_reg + 5'h01;
      in_shift_reg <= instr;
      if (instr_strobe) begin
        instr_done_reg <= 1'b1;
      end
    end
  end

  // Output shift: loaded at each word start, advanced on serial clock falls
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      out_shift_reg <= '0;
    end else if (frame_load) begin
      out_shift_reg <= sign_on_reg ? load_word : {load_word[CODE_WIDTH-2:0], 1'b0};
    end else if (sclk_fall & ~skip_fall_reg) begin
      out_shift_reg <= {out_shift_reg[CODE_WIDTH-2:0], 1'b0};
    end
  end

  // The fall after a word's last rise presents the reloaded word, so it must not shift
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      skip_fall_reg <= 1'b0;
    end else if (word_end) begin
      skip_fall_reg <= 1'b1;
    end else if (sclk_fall | cs_fall) begin
      skip_fall_reg <= 1'b0;
    end
  end

  // Data is shifted MSB first; ready rises when the word is complete
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      DOUT              <= 1'b0;
      DATA_OUTPUT_READY <= 1'b1;
    end else begin
      DOUT <= out_shift_reg[CODE_WIDTH-1];
      if (word_end | cs_rise) begin
        DATA_OUTPUT_READY <= 1'b1;
      end else if (cs_fall) begin
        DATA_OUTPUT_READY <= 1'b0;
      end
    end
  end

  // Convert request must stay high for the whole frame to skip conversion
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      req_seen_low_reg <= 1'b0;
    end else if (frame_load) begin
      req_seen_low_reg <= ~convert_request_req_n_s;
    end else if (~cs_n_s & ~convert_request_req_n_s) begin
      req_seen_low_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Mode and configuration registers
  // ------------------------------------------------------------------
  logic                       sw_pd_reg;
  logic                       test_mode_reg;
  logic [1:0]                 acq_sel_reg;
  logic                       mux_instr;
  convert_request_ctrl_pkg::chan_cfg_type pend_cfg_reg;
  logic                       convert_request_pending_reg;
  logic                       pd_eff;

  assign mux_instr = instr[convert_request_ctrl_pkg::INSTR_MUX_BIT];
  assign pd_eff    = pd_pin_s | sw_pd_reg;

  // Software power-down flag; the pin level itself is never stored here
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      sw_pd_reg <= 1'b0;
    end else if (instr_strobe & ~mux_instr & (opcode == convert_request_ctrl_pkg::OP_POWER_DOWN)) begin
      sw_pd_reg <= 1'b1;
    end else if (instr_strobe & ~mux_instr & (opcode == convert_request_ctrl_pkg::OP_POWER_UP)) begin
      sw_pd_reg <= 1'b0;
    end else if (pd_pin_fall) begin
      sw_pd_reg <= 1'b0;
    end
  end

  // Test mode only leaves through reset or the user-mode instruction
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      test_mode_reg <= 1'b0;
    end else if (instr_strobe & ~mux_instr) begin
      if (opcode == convert_request_ctrl_pkg::OP_TEST_MODE) begin
        test_mode_reg <= 1'b1;
      end else if (opcode == convert_request_ctrl_pkg::OP_USER_MODE) begin
        test_mode_reg <= 1'b0;
      end
    end
  end

  // Format, acquisition time and read-status selection
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      sign_on_reg     <= 1'b1;
      acq_sel_reg     <= convert_request_ctrl_pkg::ACQ_SEL_RESET;
      show_status_reg <= 1'b0;
    end else if (instr_strobe) begin
      show_status_reg <= ~mux_instr & (opcode == convert_request_ctrl_pkg::OP_READ_STAT);
      if (~mux_instr & (opcode == convert_request_ctrl_pkg::OP_SIGN_ON)) begin
        sign_on_reg <= 1'b1;
      end
      if (~mux_instr & (opcode == convert_request_ctrl_pkg::OP_SIGN_OFF)) begin
        sign_on_reg <= 1'b0;
      end
      if (~mux_instr & (opcode == convert_request_ctrl_pkg::OP_ACQ_TIME)) begin
        acq_sel_reg <= instr[1:0];
      end
    end
  end

  // Channel configuration waits here until the next conversion starts
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      pend_cfg_reg     <= convert_request_ctrl_pkg::CHAN_CFG_RESET;
      convert_request_pending_reg <= 1'b0;
    end else if (instr_strobe) begin
      convert_request_pending_reg <= mux_instr;
      if (mux_instr) begin
        pend_cfg_reg.single_ended <= instr[convert_request_ctrl_pkg::INSTR_SE_BIT];
        pend_cfg_reg.channel      <=
          instr[convert_request_ctrl_pkg::INSTR_CH_HI:convert_request_ctrl_pkg::INSTR_CH_LO];
      end
    end else if (word_end | cs_rise) begin
      convert_request_pending_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Conversion sequencer, stepped by conversion clock edges
  // ------------------------------------------------------------------
  convert_request_ctrl_pkg::convert_request_state_type state_reg;
  convert_request_ctrl_pkg::chan_cfg_type   act_cfg_reg;
  logic [5:0]                    step_cnt_reg;
  logic [5:0]                    acq_len;
  logic                          valid_reg;
  logic                          convert_request_start;
  logic                          convert_request_abort;
  logic signed [CODE_WIDTH-1:0]  shaped_code;

  always_comb begin
    case (acq_sel_reg)
      2'h0:    acq_len = convert_request_ctrl_pkg::ACQ_CLK_6;
      2'h1:    acq_len = convert_request_ctrl_pkg::ACQ_CLK_10;
      2'h2:    acq_len = convert_request_ctrl_pkg::ACQ_CLK_18;
      default: acq_len = convert_request_ctrl_pkg::ACQ_CLK_34;
    endcase
  end

  // A conversion starts at the end of a convert instruction's word
  assign convert_request_start = word_end & convert_request_pending_reg & req_seen_low_reg
                      & ~pd_eff & ~test_mode_reg;
  // Select falling or any power-down ends a running conversion
  assign convert_request_abort = (state_reg != convert_request_ctrl_pkg::CONVERT_REQUEST_IDLE) & (cs_fall | pd_eff);

  // Single-ended results cannot go negative, so a negative code is forced to zero
  always_comb begin
    shaped_code = SAMPLE_CODE;
    if (act_cfg_reg.single_ended && SAMPLE_CODE[CODE_WIDTH-1]) begin
      shaped_code = '0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_reg    <= convert_request_ctrl_pkg::CONVERT_REQUEST_IDLE;
      act_cfg_reg  <= convert_request_ctrl_pkg::CHAN_CFG_RESET;
      step_cnt_reg <= 6'h00;
    end else if (convert_request_abort) begin
      state_reg <= convert_request_ctrl_pkg::CONVERT_REQUEST_IDLE;
    end else begin
      case (state_reg)
        convert_request_ctrl_pkg::CONVERT_REQUEST_IDLE: begin
          if (convert_request_start) begin
            act_cfg_reg  <= pend_cfg_reg;
            step_cnt_reg <= 6'h00;
            state_reg    <= convert_request_ctrl_pkg::CONVERT_REQUEST_ACQUIRE;
          end
        end
        convert_request_ctrl_pkg::CONVERT_REQUEST_ACQUIRE: begin
          if (conversion_clock_rise) begin
            if (step_cnt_reg == acq_len - 6'h01) begin
              step_cnt_reg <= 6'h00;
              state_reg    <= convert_request_ctrl_pkg::CONVERT_REQUEST_RUN;
            end else begin
              step_cnt_reg <= step_cnt_reg + 6'h01;
            end
          end
        end
        convert_request_ctrl_pkg::CONVERT_REQUEST_RUN: begin
          if (conversion_clock_rise) begin
            if (step_cnt_reg == 6'(CODE_WIDTH - 1)) begin
              state_reg <= convert_request_ctrl_pkg::CONVERT_REQUEST_IDLE;
            end else begin
              step_cnt_reg <= step_cnt_reg + 6'h01;
            end
          end
        end
        default: state_reg <= convert_request_ctrl_pkg::CONVERT_REQUEST_IDLE;
      endcase
    end
  end

  // Result register; an aborted conversion leaves the data marked unusable
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      result_reg <= '0;
      valid_reg  <= 1'b0;
    end else if (convert_request_abort) begin
      valid_reg <= 1'b0;
    end else if ((state_reg == convert_request_ctrl_pkg::CONVERT_REQUEST_RUN) & conversion_clock_rise
                 & (step_cnt_reg == 6'(CODE_WIDTH - 1))) begin
      result_reg <= shaped_code;
      valid_reg  <= 1'b1;
    end
  end

  // Status word contents
  always_comb begin
    status_word = '0;
    status_word[convert_request_ctrl_pkg::STAT_TEST_BIT]  = test_mode_reg;
    status_word[convert_request_ctrl_pkg::STAT_PD_BIT]    = pd_eff;
    status_word[convert_request_ctrl_pkg::STAT_BUSY_BIT]  = state_reg != convert_request_ctrl_pkg::CONVERT_REQUEST_IDLE;
    status_word[convert_request_ctrl_pkg::STAT_VALID_BIT] = valid_reg;
    status_word[convert_request_ctrl_pkg::STAT_SIGN_BIT]  = sign_on_reg;
    status_word[1:0]                           = acq_sel_reg;
  end

  // ------------------------------------------------------------------
  // Multiplexer routing and analog control outputs
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      MUX_ROUTE <= '0;
    end else if (act_cfg_reg.single_ended) begin
      MUX_ROUTE.first_sel     <= act_cfg_reg.channel;
      MUX_ROUTE.second_common <= 1'b1;
      MUX_ROUTE.second_sel    <= 3'h0;
      MUX_ROUTE.swap          <= 1'b0;
    end else begin
      MUX_ROUTE.first_sel     <= {act_cfg_reg.channel[2:1], 1'b0};
      MUX_ROUTE.second_common <= 1'b0;
      MUX_ROUTE.second_sel    <= {act_cfg_reg.channel[2:1], 1'b1};
      MUX_ROUTE.swap          <= act_cfg_reg.channel[0];
    end
  end

  // Channel pins turn into outputs in test mode; they drive low for safety
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      CONVERTER_ENABLE <= 1'b1;
      SAMPLE_HOLD      <= 1'b0;
      CONVERTING       <= 1'b0;
      TEST_MODE        <= 1'b0;
      CHANNEL_OE       <= 8'h00;
      CHANNEL_OUT      <= 8'h00;
    end else begin
      CONVERTER_ENABLE <= ~pd_eff;
      SAMPLE_HOLD      <= state_reg == convert_request_ctrl_pkg::CONVERT_REQUEST_ACQUIRE;
      CONVERTING       <= state_reg != convert_request_ctrl_pkg::CONVERT_REQUEST_IDLE;
      TEST_MODE        <= test_mode_reg;
      CHANNEL_OE       <= {8{test_mode_reg}};
      CHANNEL_OUT      <= 8'h00;
    end
  end

endmodule

// File: sim/convert_request_ctrl_monitor.sv
// Concurrent checks on the converter control ports
`timescale 1ns/100ps
module convert_request_ctrl_monitor (
  input wire logic                         CLK_SYS,           // Clock
  input wire logic                         RSTN,              // Reset
  input wire logic                         CS_N,              // Select
  input wire logic                         CONVERT_REQUEST_N, // Convert request
  input wire logic                         POWER_DOWN_PIN,    // Power-down pin
  input wire logic                         DATA_OUTPUT_READY, // Word done
  input wire convert_request_ctrl_pkg::mux_route_type MUX_ROUTE,         // Routing
  input wire logic                         CONVERTER_ENABLE,  // Converter on
  input wire logic                         SAMPLE_HOLD,       // Acquiring
  input wire logic                         CONVERTING,        // Busy
  input wire logic                         TEST_MODE,         // Test mode
  input wire logic [7:0]                   CHANNEL_OE         // Pin enables
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // Pin repetition allows for the two-stage synchroniser
  property p_pin_pd; POWER_DOWN_PIN [*5] |-> !CONVERTER_ENABLE; endproperty
  a_pin_pd: assert property (p_pin_pd) else $error("pin power-down ignored");
  property p_test_oe; TEST_MODE [*3] |-> CHANNEL_OE == 8'hff; endproperty
  a_test_oe: assert property (p_test_oe) else $error("test pins not driven");
  property p_pd_idle; !CONVERTER_ENABLE [*3] |-> !CONVERTING && !SAMPLE_HOLD; endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("converting while down");
  property p_cs_abort; $fell(CS_N) && CONVERTING |-> ##[1:8] !CONVERTING; endproperty
  a_cs_abort: assert property (p_cs_abort) else $error("select fall no abort");
  property p_se_pol; MUX_ROUTE.second_common |-> !MUX_ROUTE.swap; endproperty
  a_se_pol: assert property (p_se_pol) else $error("single-ended swapped");
  property p_pair;
    !MUX_ROUTE.second_common && MUX_ROUTE != '0 |->
      !MUX_ROUTE.first_sel[0] && MUX_ROUTE.second_sel == (MUX_ROUTE.first_sel | 3'h1);
  endproperty
  a_pair: assert property (p_pair) else $error("bad differential pair");
  property p_read_only; $rose(CONVERTING) |-> !$past(CONVERT_REQUEST_N, 4); endproperty
  a_read_only: assert property (p_read_only) else $error("read-only converted");
  property p_ready; CS_N [*5] |-> DATA_OUTPUT_READY; endproperty
  a_ready: assert property (p_ready) else $error("ready low while idle");
  c_test: cover property ($rose(TEST_MODE));
  c_done: cover property ($fell(CONVERTING));
  c_pd: cover property ($fell(CONVERTER_ENABLE));
endmodule
bind convert_request_ctrl convert_request_ctrl_monitor i_convert_request_ctrl_monitor (.CLK_SYS, .RSTN, .CS_N,
  .CONVERT_REQUEST_N, .POWER_DOWN_PIN, .DATA_OUTPUT_READY, .MUX_ROUTE,
  .CONVERTER_ENABLE, .SAMPLE_HOLD, .CONVERTING, .TEST_MODE, .CHANNEL_OE);

// File: sim/host_model.sv
// Host controller model driving the serial instruction link
`timescale 1ns/100ps
module host_model (
  input  wire logic CLK_SYS, // System clock
  input  wire logic DOUT,    // Data from device
  output logic      CS_N,    // Chip select
  output logic      SCLK,    // Link clock, still between frames
  output logic      DIN      // Data to device
);
  initial begin
    CS_N = 1'b1;
    SCLK = 1'b0;
    DIN = 1'b0;
  end
  // One framed 13-clock word; DIN toggles after the instruction so no stale level lingers
  task automatic xfer(input logic [7:0] ins, output logic [12:0] word);
    @(negedge CLK_SYS) CS_N = 1'b0;
    repeat (8) @(negedge CLK_SYS);
    for (int i = 12; i >= 0; i--) begin
      DIN = (i > 4) ? ins[i-5] : ~DIN;
      repeat (4) @(negedge CLK_SYS);
      // Bit taken before the rise: the last rise reloads the device's shift register
      word[i] = DOUT;
      SCLK = 1'b1;
      repeat (4) @(negedge CLK_SYS);
      SCLK = 1'b0;
    end
    repeat (8) @(negedge CLK_SYS);
    CS_N = 1'b1;
    repeat (8) @(negedge CLK_SYS);
  endtask
endmodule

// File: sim/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module tb;
  logic clk_sys, rstn, cs_n, sclk, din, convert_request_n, pd_pin, conversion_clock, dout;
  logic ready, convert_request_en, hold, busy, test;
  logic [12:0] code, word;
  logic [7:0] oe, pins;
  convert_request_ctrl_pkg::mux_route_type route;
  int num_errors = 0;
  int num_checks = 0;
  convert_request_ctrl i_convert_request_ctrl (.CLK_SYS(clk_sys), .RSTN(rstn), .CS_N(cs_n), .SCLK(sclk),
    .DIN(din), .CONVERT_REQUEST_N(convert_request_n), .POWER_DOWN_PIN(pd_pin),
    .CONVERSION_CLOCK(conversion_clock), .SAMPLE_CODE(code), .DOUT(dout), .DATA_OUTPUT_READY(ready),
    .MUX_ROUTE(route), .CONVERTER_ENABLE(convert_request_en), .SAMPLE_HOLD(hold), .CONVERTING(busy),
    .TEST_MODE(test), .CHANNEL_OE(oe), .CHANNEL_OUT(pins));
  host_model i_host_model (.CLK_SYS(clk_sys), .DOUT(dout), .CS_N(cs_n), .SCLK(sclk),
    .DIN(din));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Conversion clock free-running, unrelated to the link
  initial begin
    conversion_clock = 1'b0;
    forever #50 conversion_clock = ~conversion_clock;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic xf(input logic [7:0] ins);
    i_host_model.xfer(ins, word);
  endtask
  // Status arrives in the word after the request
  task automatic stat;
    xf(8'h20);
    xf(8'h30);
  endtask
  task automatic wait_done;
    for (int n = 0; n < 400 && busy === 1'b1; n++) @(negedge clk_sys);
    check(16'(busy), 16'h0000);
  endtask
  initial begin
    #(16000 * 25);
    num_errors++;
    report_and_stop;
  end
  initial begin
    rstn = 1'b0;
    convert_request_n = 1'b0;
    pd_pin = 1'b0;
    code = 13'h1abc;
    repeat (16) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    check(16'({test, convert_request_en, ready, oe}), 16'h0300);
    xf(8'h10);
    check(16'(convert_request_en), 16'h0000);
    stat;
    check(16'(word[8]), 16'h0001);
    pd_pin = 1'b1;
    xf(8'h00);
    check(16'(convert_request_en), 16'h0000);
    pd_pin = 1'b0;
    xf(8'h10);
    pd_pin = 1'b1;
    repeat (6) @(negedge clk_sys);
    pd_pin = 1'b0;
    repeat (6) @(negedge clk_sys);
    check(16'(convert_request_en), 16'h0001);
    $display("power test done");
    xf(8'h60);
    check(16'({test, oe}), 16'h01ff);
    check(16'(pins), 16'h0000);
    stat;
    check(16'(word[9]), 16'h0001);
    xf(8'h70);
    xf(8'h00);
    xf(8'h52);
    stat;
    check(16'({word[9], test, oe}), 16'h0000);
    check(16'(word[2:0]), 16'h0006);
    $display("mode test done");
    xf(8'hc8);
    check(16'({route.first_sel, route.second_common, route.swap}), 16'h0006);
    check(16'({busy, hold}), 16'h0003);
    wait_done;
    convert_request_n = 1'b1;
    xf(8'h98);
    check(16'({busy, word}), 16'h0000);
    convert_request_n = 1'b0;
    code = 13'h1000;
    xf(8'h98);
    check(16'(route), 16'h0047);
    wait_done;
    convert_request_n = 1'b1;
    repeat (2) begin
      xf(8'h98);
      check(16'({busy, ready, word}), 16'h3000);
    end
    $display("convert test done");
    convert_request_n = 1'b0;
    xf(8'h98);
    pd_pin = 1'b1;
    repeat (8) @(negedge clk_sys);
    pd_pin = 1'b0;
    stat;
    check(16'({busy, word[6]}), 16'h0000);
    xf(8'h98);
    wait_done;
    xf(8'h98);
    stat;
    check(16'({busy, word[6]}), 16'h0000);
    $display("abort test done");
    // Mid-run reset stands in for a brown-out: defaults return, then the host reprograms
    rstn = 1'b0;
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    stat;
    check(16'(word[9:0]), 16'h0005);
    xf(8'h00);
    xf(8'h52);
    stat;
    check(16'(word[2:0]), 16'h0006);
    $display("reset test done");
    report_and_stop;
  end
endmodule
